// *** core/pra_pkg.sv ***
// Purpose: Shared constants and types for the rung action unit.
// Assumes: Rung words are byte-packed: cond A, operator, cond B, action.
// Notes:   Only the action codes handled by this unit are listed.
package pra_pkg;

   localparam int          PRA_NUM_RUNGS     = 30;
   localparam int          PRA_NUM_VARS      = 10;
   localparam int          PRA_NUM_TIMERS    = 4;
   localparam int          PRA_NUM_INPUTS    = 8;

   // Condition codes
   localparam logic [7:0]  COND_FALSE        = 8'h00;
   localparam logic [7:0]  COND_TRUE         = 8'h01;
   localparam logic [7:0]  COND_INPUT_BASE   = 8'h32;
   localparam logic [7:0]  COND_VAR_BASE     = 8'h64;

   // Operator codes
   localparam logic [7:0]  OP_OR             = 8'h00;
   localparam logic [7:0]  OP_AND            = 8'h01;
   localparam logic [7:0]  OP_XOR            = 8'h02;
   localparam logic [7:0]  OP_NOR            = 8'h03;

   // Action codes
   localparam logic [7:0]  ACT_PRESET_BIT0   = 8'h19;
   localparam logic [7:0]  ACT_TABLE_BIT0    = 8'h23;
   localparam logic [7:0]  ACT_VAR_BASE      = 8'h28;
   localparam logic [7:0]  ACT_PULSE_TMR_D   = 8'h3D;
   localparam logic [7:0]  ACT_LOGIC_RESET   = 8'h45;
   localparam logic [7:0]  ACT_JUMP_BASE     = 8'h46;
   localparam logic [7:0]  ACT_JUMP_LAST     = 8'h63;
   localparam logic [7:0]  ACT_HEATER        = 8'h96;

   localparam int          TMR_D_IDX         = 3;
   localparam logic [3:0]  PRESET_ZERO_SPEED = 4'hF;
   localparam logic [3:0]  PRESET_RESET      = 4'h0;
   localparam logic [1:0]  TABLE_RESET       = 2'h0;

   typedef struct packed {
      logic [7:0] cond_a;
      logic [7:0] oper;
      logic [7:0] cond_b;
      logic [7:0] action;
   } pra_rung_s;

   typedef struct packed {
      logic       zero_speed;
      logic [3:0] preset_num;
      logic [2:0] table_num;
   } pra_select_s;

endpackage

// *** core/pra_rung_eval.sv ***
// Purpose: Combinational evaluation of one rung's condition.
// Assumes: Condition codes outside the known ranges read as false.
// Notes:   Pure logic, no state.
`timescale 1ns/1ps
`default_nettype none
module pra_rung_eval
   import pra_pkg::*;
(
   input  wire pra_rung_s                  rung,
   input  wire logic [PRA_NUM_INPUTS-1:0]  din,
   input  wire logic [PRA_NUM_VARS-1:0]    vars,
   output logic                            result
);

   function automatic logic cond_val(input logic [7:0] code,
                                     input logic [PRA_NUM_INPUTS-1:0] di,
                                     input logic [PRA_NUM_VARS-1:0] v);
      logic r;
      r = 1'b0;
      if (code == COND_TRUE)
         r = 1'b1;
      else if (code >= COND_INPUT_BASE && code < COND_INPUT_BASE + 8'(PRA_NUM_INPUTS))
         r = di[3'(code - COND_INPUT_BASE)];
      else if (code >= COND_VAR_BASE && code < COND_VAR_BASE + 8'(PRA_NUM_VARS))
         r = v[4'(code - COND_VAR_BASE)];
      return r;
   endfunction

   logic a;
   logic b;

   always_comb
   begin
      a = cond_val(rung.cond_a, din, vars);
      b = cond_val(rung.cond_b, din, vars);
      case (rung.oper)
         OP_OR:   result = a | b;
         OP_AND:  result = a & b;
         OP_XOR:  result = a ^ b;
         OP_NOR:  result = ~(a | b);
         default: result = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// *** core/pra_rung_unit.sv ***
// Purpose: Rung scanner firing pulse-restart, logic reset, jump, heater,
//          preset-speed and parameter-table actions.
// Assumes: One rung evaluated per clock; rung words stable during a scan.
// Notes:   Rung pointer holds at rung 0 while the mode is off.
// Contract
// - Pulse restart of timer D acts only when true and timer D has expired.
// - Logic reset expires every timer and clears every logical variable.
// - Logic reset leaves comparator state untouched.
// - Jump codes 70..99 move evaluation to rung code-70, skipping between.
// - Only forward jumps are taken; same or lower target raises an error.
// - Heater enable follows its action's condition.
// - Actions 25..28 drive preset index bits 0..3 from their conditions.
// - Preset index n selects speed n+1, all ones selects zero speed.
// - Table index uses action 35 as low bit and 36 as high; 0..3 pick tables 1..4.
// - Undriven preset index bits stay zero, giving preset speed 1.
// - Input NOR false fires the action while the input is low.
// - Table bits follow their condition and stay clear when never driven.
// - Rungs are evaluated in ascending order so later rungs see earlier writes.
`timescale 1ns/1ps
`default_nettype none
module pra_rung_unit
   import pra_pkg::*;
#(
   parameter int NUM_RUNGS = PRA_NUM_RUNGS
)(
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       plc_mode_en,
   input  wire logic [32*NUM_RUNGS-1:0]    first_rung_word,
   input  wire logic [PRA_NUM_INPUTS-1:0]  din,
   input  wire logic [PRA_NUM_TIMERS-1:0]  tmr_expired,
   output logic                            tmr_d_restart,
   output logic                            tmr_expire_all,
   output logic                            heater_en,
   output logic [3:0]                      preset_idx,
   output pra_select_s                     active_table_selector,
   output logic [PRA_NUM_VARS-1:0]         vars_ff,
   output logic                            jump_err,
   output logic                            scan_done
);

   initial
   begin
      if (NUM_RUNGS < 2 || NUM_RUNGS > PRA_NUM_RUNGS)
         $error("NUM_RUNGS out of range");
   end

   // ------------------------------------------------------------
   // Scan sequencing
   // ------------------------------------------------------------
   localparam int RW = $clog2(PRA_NUM_RUNGS);

   logic [RW-1:0]  rung_ff;
   logic [RW-1:0]  nxt_rung;
   pra_rung_s      cur;
   logic           fire;
   logic           is_jump;
   logic [7:0]     jump_tgt;
   logic           jump_ok;
   logic           last_rung;

   always_comb
   begin
      cur      = pra_rung_s'(first_rung_word[32*rung_ff +: 32]);
      is_jump  = cur.action >= ACT_JUMP_BASE && cur.action <= ACT_JUMP_LAST;
      jump_tgt = cur.action - ACT_JUMP_BASE;
      jump_ok  = jump_tgt > 8'(rung_ff) && jump_tgt < 8'(NUM_RUNGS);
      last_rung = rung_ff == RW'(NUM_RUNGS - 1);
   end

   pra_rung_eval u_eval (
      .rung   (cur),
      .din    (din),
      .vars   (vars_ff),
      .result (fire)
   );

   always_comb
   begin
      if (fire && is_jump && jump_ok)
         nxt_rung = RW'(jump_tgt);
      else if (last_rung)
         nxt_rung = '0;
      else
         nxt_rung = rung_ff + RW'(1);
   end

   always_ff @(posedge core_clk)
   begin
      if (rst || !plc_mode_en)
         rung_ff <= '0;
      else
         rung_ff <= nxt_rung;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         scan_done <= 1'b0;
      else
         scan_done <= plc_mode_en && last_rung;
   end

   // ------------------------------------------------------------
   // Jump error
   // ------------------------------------------------------------
   // Sticky until reset so software can see a single bad rung.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         jump_err <= 1'b0;
      else if (plc_mode_en && fire && is_jump && !jump_ok)
         jump_err <= 1'b1;
   end

   // ------------------------------------------------------------
   // Logical variables and timer actions
   // ------------------------------------------------------------
   logic do_reset;
   assign do_reset = plc_mode_en && fire && cur.action == ACT_LOGIC_RESET;

   // Comparator state lives outside this unit, so reset cannot touch it.
   always_ff @(posedge core_clk)
   begin
      if (rst || do_reset)
         vars_ff <= '0;
      else if (plc_mode_en)
         for (int i = 0; i < PRA_NUM_VARS; i++)
            if (cur.action == ACT_VAR_BASE + 8'(i))
               vars_ff[i] <= fire;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         tmr_d_restart  <= 1'b0;
         tmr_expire_all <= 1'b0;
      end
      else
      begin
         tmr_d_restart  <= plc_mode_en && fire && cur.action == ACT_PULSE_TMR_D
                           && tmr_expired[TMR_D_IDX];
         tmr_expire_all <= do_reset;
      end
   end

   // ------------------------------------------------------------
   // Heater, preset and table index bits
   // ------------------------------------------------------------
   logic [1:0] table_idx_ff;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         heater_en    <= 1'b0;
         preset_idx   <= PRESET_RESET;
         table_idx_ff <= TABLE_RESET;
      end
      else if (plc_mode_en)
      begin
         if (cur.action == ACT_HEATER)
            heater_en <= fire;
         for (int i = 0; i < 4; i++)
            if (cur.action == ACT_PRESET_BIT0 + 8'(i))
               preset_idx[i] <= fire;
         for (int i = 0; i < 2; i++)
            if (cur.action == ACT_TABLE_BIT0 + 8'(i))
               table_idx_ff[i] <= fire;
      end
   end

   // ------------------------------------------------------------
   // Index decode
   // ------------------------------------------------------------
   always_comb
   begin
      active_table_selector.zero_speed = preset_idx == PRESET_ZERO_SPEED;
      active_table_selector.preset_num = active_table_selector.zero_speed ? 4'h0
                                         : preset_idx + 4'h1;
      active_table_selector.table_num  = {1'b0, table_idx_ff} + 3'h1;
   end

   // ------------------------------------------------------------
   // Checks: sequencing and jumps
   // ------------------------------------------------------------
   a_jump_forward: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && fire && is_jump && jump_ok |=> rung_ff == $past(RW'(jump_tgt)))
      else $error("jump target not reached");

   a_jump_error: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && fire && is_jump && !jump_ok |=> jump_err)
      else $error("bad jump not flagged");

   a_jump_no_back: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && fire && is_jump && !jump_ok && !last_rung
      |=> rung_ff == $past(rung_ff) + RW'(1))
      else $error("backward jump taken");

   a_error_sticky: assert property (@(posedge core_clk) disable iff (rst)
      jump_err |=> jump_err)
      else $error("jump error lost");

   a_order_step: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && !(fire && is_jump) && !last_rung |=> rung_ff == $past(rung_ff) + RW'(1))
      else $error("rung order broken");

   a_scan_wrap: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && last_rung |=> rung_ff == '0 && scan_done)
      else $error("scan did not wrap");

   a_scan_pulse: assert property (@(posedge core_clk) disable iff (rst)
      scan_done |-> $past(last_rung) && $past(plc_mode_en))
      else $error("stray scan end");

   a_mode_off_hold: assert property (@(posedge core_clk) disable iff (rst)
      !plc_mode_en |=> rung_ff == '0 && $stable(preset_idx) && $stable(vars_ff))
      else $error("idle mode not holding");

   // ------------------------------------------------------------
   // Checks: conditions, variables and timers
   // ------------------------------------------------------------
   a_false_never: assert property (@(posedge core_clk) disable iff (rst)
      cur.cond_a == COND_FALSE && cur.cond_b == COND_FALSE && cur.oper != OP_NOR |-> !fire)
      else $error("constant false fired");

   a_nor_low_fire: assert property (@(posedge core_clk) disable iff (rst)
      cur.oper == OP_NOR && cur.cond_b == COND_FALSE && cur.cond_a >= COND_INPUT_BASE
      && cur.cond_a < COND_INPUT_BASE + 8'(PRA_NUM_INPUTS)
      |-> fire == !din[3'(cur.cond_a - COND_INPUT_BASE)])
      else $error("inverted input did not fire");

   a_vars_write: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_VAR_BASE |=> vars_ff[0] == $past(fire))
      else $error("variable A not written");

   a_reset_vars: assert property (@(posedge core_clk) disable iff (rst)
      do_reset |=> vars_ff == '0 && tmr_expire_all)
      else $error("logic reset incomplete");

   a_expire_cause: assert property (@(posedge core_clk) disable iff (rst)
      tmr_expire_all |-> $past(do_reset))
      else $error("stray expire pulse");

   a_pulse_restart: assert property (@(posedge core_clk) disable iff (rst)
      tmr_d_restart |-> $past(tmr_expired[TMR_D_IDX]) && $past(fire))
      else $error("timer D restarted while running");

   a_restart_cause: assert property (@(posedge core_clk) disable iff (rst)
      tmr_d_restart |-> $past(plc_mode_en) && $past(cur.action == ACT_PULSE_TMR_D))
      else $error("restart without its action");

   a_restart_forced: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && fire && cur.action == ACT_PULSE_TMR_D && tmr_expired[TMR_D_IDX]
      |=> tmr_d_restart)
      else $error("expired timer D not restarted");

   // ------------------------------------------------------------
   // Checks: drive outputs
   // ------------------------------------------------------------
   a_heater_follow: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_HEATER |=> heater_en == $past(fire))
      else $error("heater not following");

   a_heater_hold: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action != ACT_HEATER |=> $stable(heater_en))
      else $error("heater changed by other rung");

   a_preset_bit: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_PRESET_BIT0 |=> preset_idx[0] == $past(fire))
      else $error("preset bit 0 wrong");

   a_preset_bit_one: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_PRESET_BIT0 + 8'h01 |=> preset_idx[1] == $past(fire))
      else $error("preset bit 1 wrong");

   a_preset_bit_two: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_PRESET_BIT0 + 8'h02 |=> preset_idx[2] == $past(fire))
      else $error("preset bit 2 wrong");

   a_preset_bit_three: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_PRESET_BIT0 + 8'h03 |=> preset_idx[3] == $past(fire))
      else $error("preset bit 3 wrong");

   a_zero_speed: assert property (@(posedge core_clk) disable iff (rst)
      preset_idx == 4'hF |-> active_table_selector.zero_speed
      && active_table_selector.preset_num == 4'h0)
      else $error("zero speed decode wrong");

   a_preset_decode: assert property (@(posedge core_clk) disable iff (rst)
      preset_idx != PRESET_ZERO_SPEED |-> !active_table_selector.zero_speed
      && active_table_selector.preset_num - 4'h1 == preset_idx)
      else $error("preset speed decode wrong");

   a_table_bit_low: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_TABLE_BIT0 |=> table_idx_ff[0] == $past(fire))
      else $error("table bit 0 wrong");

   a_table_bit_high: assert property (@(posedge core_clk) disable iff (rst)
      plc_mode_en && cur.action == ACT_TABLE_BIT0 + 8'h01 |=> table_idx_ff[1] == $past(fire))
      else $error("table bit 1 wrong");

   a_table_decode: assert property (@(posedge core_clk) disable iff (rst)
      active_table_selector.table_num == (table_idx_ff == 2'h0 ? 3'h1
      : table_idx_ff == 2'h1 ? 3'h2 : table_idx_ff == 2'h2 ? 3'h3 : 3'h4))
      else $error("table decode wrong");

endmodule
`default_nettype wire

// *** tb/pra_tmr_model.sv ***
// Purpose: Behavioural timer core beside the rung unit.
// Assumes: Timers run (not expired) after reset.
// Notes:   Timer D expires RUN_CYC cycles after a restart.
`timescale 1ns/1ps
`default_nettype none
module pra_tmr_model
#(
   parameter int RUN_CYC = 6
)(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       restart_d,
   input  wire logic       expire_all,
   output logic [3:0]      expired_ff
);
   int cnt_ff;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         expired_ff <= 4'h0;
         cnt_ff     <= 0;
      end
      else if (expire_all)
         expired_ff <= 4'hF;
      else if (restart_d)
      begin
         expired_ff[3] <= 1'b0;
         cnt_ff        <= RUN_CYC;
      end
      else if (cnt_ff != 0)
      begin
         cnt_ff <= cnt_ff - 1;
         if (cnt_ff == 1)
            expired_ff[3] <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the rung action unit.
// Assumes: Eight rungs per scan; each scan ends with scan_done.
// Notes:   Reset between scenarios puts the pointer back at rung 0.
`timescale 1ns/1ps
`default_nettype none
module tb
   import pra_pkg::*;
   ;
   localparam int      NR = 8;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   logic               en = 1'b0;
   logic [32*NR-1:0]   rungs = '0;
   logic [7:0]         din = 8'h00;
   logic [3:0]         tmr_expired;
   logic               tmr_d_restart, tmr_expire_all, heater_en, jump_err, scan_done;
   logic [3:0]         preset_idx;
   pra_select_s        sel;
   logic [9:0]         vars_ff;
   int                 n_fail = 0;
   int                 checks_done = 0;

   always #20 core_clk = ~core_clk;

   pra_rung_unit #(.NUM_RUNGS(NR)) uut (.core_clk(core_clk), .rst(rst), .plc_mode_en(en),
      .first_rung_word(rungs), .din(din), .tmr_expired(tmr_expired),
      .tmr_d_restart(tmr_d_restart), .tmr_expire_all(tmr_expire_all), .heater_en(heater_en),
      .preset_idx(preset_idx), .active_table_selector(sel), .vars_ff(vars_ff),
      .jump_err(jump_err), .scan_done(scan_done));
   pra_tmr_model tmr (.core_clk(core_clk), .rst(rst), .restart_d(tmr_d_restart),
      .expire_all(tmr_expire_all), .expired_ff(tmr_expired));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic complete_run;
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   function automatic logic [31:0] rw(input logic [7:0] a, o, b, c);
      return {a, o, b, c};
   endfunction

   task automatic start(input logic [32*NR-1:0] prog, input logic [7:0] d0);
      @(posedge core_clk);
      rst   <= 1'b1;
      din   <= d0;
      en    <= 1'b0;
      rungs <= prog;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      en  <= 1'b1;
   endtask

   // Bounded wait so a dead scanner cannot hang the run
   task automatic wait_scan;
      int i;
      i = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         i++;
      end
      while (scan_done !== 1'b1 && i < 4*NR);
      chk(scan_done, 1'b1, "scan never completed");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      @(posedge core_clk);
      #1;
      chk(preset_idx, 4'h0, "preset index after reset");
      chk(sel, {1'b0, 4'h1, 3'h1}, "selector after reset");
      chk({heater_en, vars_ff, jump_err}, 12'h000, "outputs after reset");
   endtask

   task automatic t_select;
      logic [7:0] d;
      logic [3:0] idx;
      start({32'h0, rw(8'h38, 8'h00, 8'h00, 8'h96), rw(8'h37, 8'h00, 8'h00, 8'h24),
             rw(8'h36, 8'h00, 8'h00, 8'h23), rw(8'h35, 8'h03, 8'h00, 8'h1C),
             rw(8'h34, 8'h02, 8'h01, 8'h1B), rw(8'h33, 8'h01, 8'h01, 8'h1A),
             rw(8'h32, 8'h00, 8'h00, 8'h19)}, 8'h00);
      for (int i = 0; i < 16; i++)
      begin
         d = {4'(i) ^ 4'h5, 4'(i)};
         @(posedge core_clk);
         din <= d;
         wait_scan();
         wait_scan();
         idx = {~d[3], ~d[2], d[1], d[0]};
         chk(preset_idx, idx, "preset index bits");
         chk(sel, {idx == 4'hF, (idx == 4'hF) ? 4'h0 : idx + 4'h1,
             3'({d[5], d[4]}) + 3'h1}, "selector decode");
         chk(heater_en, d[6], "heater follows condition");
      end
      chk(jump_err, 1'b0, "error without jumps");
   endtask

   task automatic t_order_reset;
      int i;
      start({128'h0, rw(8'h37, 8'h00, 8'h00, 8'h45), rw(8'h65, 8'h01, 8'h01, 8'h96),
             rw(8'h64, 8'h00, 8'h00, 8'h29), rw(8'h39, 8'h00, 8'h00, 8'h28)}, 8'h80);
      wait_scan();
      chk({heater_en, vars_ff}, 11'h403, "later rungs see earlier writes");
      @(posedge core_clk);
      din <= 8'hA0;
      i = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         i++;
      end
      while (tmr_expire_all !== 1'b1 && i < 3*NR);
      chk(tmr_expire_all, 1'b1, "logic reset pulse");
      chk(vars_ff, 10'h000, "logic reset clears variables");
      @(posedge core_clk);
      #1;
      chk({tmr_expire_all, tmr_expired}, 5'h0F, "timers expired, pulse single");
   endtask

   task automatic t_pulse;
      int n;
      start({192'h0, rw(8'h37, 8'h00, 8'h00, 8'h45), rw(8'h01, 8'h00, 8'h00, 8'h3D)}, 8'h00);
      n = 0;
      repeat (3*NR)
      begin
         @(posedge core_clk);
         #1;
         if (tmr_d_restart === 1'b1)
            n++;
      end
      chk(n, 0, "restart while timer running");
      @(posedge core_clk);
      din <= 8'h20;
      repeat (3*NR)
      begin
         @(posedge core_clk);
         #1;
         if (tmr_d_restart === 1'b1)
            n++;
      end
      chk(n > 0, 1'b1, "no restart of expired timer");
   endtask

   task automatic t_jump;
      start({32'h0, rw(8'h01, 8'h00, 8'h00, 8'h46), rw(8'h01, 8'h00, 8'h00, 8'h29),
             rw(8'h01, 8'h00, 8'h00, 8'h48), rw(8'h01, 8'h00, 8'h00, 8'h28),
             rw(8'h01, 8'h00, 8'h00, 8'h19), rw(8'h01, 8'h00, 8'h00, 8'h96),
             rw(8'h01, 8'h00, 8'h00, 8'h49)}, 8'h00);
      wait_scan();
      chk({heater_en, preset_idx}, 5'h00, "skipped rungs executed");
      chk(vars_ff, 10'h003, "rungs after jumps");
      chk(jump_err, 1'b1, "backward jump error");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_select();
      t_order_reset();
      t_pulse();
      t_jump();
      complete_run();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
